// ==== design/wra_top.sv ====
// Sequencer for the wide range analog input subsystem.
`timescale 1ns/1ps
module wra_top #(
   parameter int PER_STD = wra_pkg::PER_STD_CYC,
   parameter int PER_ZS = wra_pkg::PER_ZS_CYC,
   parameter int PER_AUTO = wra_pkg::PER_AUTO_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire logic [wra_pkg::CMD_W-1:0] cmd_word_i,
   input wire logic ofs_valid_i,
   input wire logic [wra_pkg::OFS_W-1:0] ofs_word_i,
   input wire logic amp_cmp_i,
   input wire logic sar_cmp_i,
   input wire logic read_i,
   output logic [wra_pkg::NCHAN-1:0] chan_sel_o,
   output logic [wra_pkg::GAIN_W-1:0] gain_o,
   output logic hold_o,
   output logic [wra_pkg::RES_W-1:0] dac_o,
   output logic [wra_pkg::OFS_W-1:0] ofs_dac_o,
   output logic [wra_pkg::SER_W-1:0] result_o,
   output logic ready_o,
   output logic ser_data_o,
   output logic ser_valid_o,
   output logic busy_o
);
   wra_conv_if cv ();

   wra_sar u_sar (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .cv(cv)
   );

   function automatic logic [wra_pkg::NCHAN-1:0] chan_decode(
      input logic [wra_pkg::CHAN_W-1:0] ch);
      chan_decode = {{(wra_pkg::NCHAN-1){1'b0}}, 1'b1} << ch;
   endfunction

   wra_pkg::wra_state_type state_ff;
   logic [wra_pkg::CMD_W-1:0] hold_word_ff;
   logic pend_ff;
   logic auto_ff;
   logic zsup_ff;
   logic [15:0] wait_ff;
   logic [15:0] period_ff;
   logic [wra_pkg::OFS_W-1:0] ofs_ff;
   logic [wra_pkg::GAIN_W-1:0] conv_gain_ff;
   logic [wra_pkg::SER_W-1:0] stage_ff;
   logic stage_vld_ff;
   logic [wra_pkg::SER_W-1:0] shift_ff;
   logic [4:0] shift_cnt_ff;
   logic take;
   logic fire;
   logic load;
   logic [15:0] gap_ff;
   logic [15:0] need_ff;

   // The held word is taken only from idle, which is also right after a
   // conversion has been started, so the next channel settles meanwhile.
   assign take = (state_ff == wra_pkg::ST_IDLE) && pend_ff;
   assign fire = (state_ff == wra_pkg::ST_START) && !cv.busy;
   assign load = stage_vld_ff && (!ready_o || read_i);
   assign cv.start = fire;
   assign cv.cmp = sar_cmp_i;

   // ==========================================================
   // Holding register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hold_word_ff <= '0;
         pend_ff <= 1'b0;
      end else begin
         if (cmd_valid_i) begin
            hold_word_ff <= cmd_word_i;
         end
         if (cmd_valid_i) begin
            pend_ff <= 1'b1;
         end else if (take) begin
            pend_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Offset register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ofs_ff <= '0;
      end else if (ofs_valid_i) begin
         ofs_ff <= ofs_word_i;
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= wra_pkg::ST_IDLE;
         chan_sel_o <= '0;
         gain_o <= wra_pkg::GAIN_MIN;
         auto_ff <= 1'b0;
         zsup_ff <= 1'b0;
         wait_ff <= '0;
      end else begin
         if (wait_ff != 16'h0000) begin
            wait_ff <= wait_ff - 16'h0001;
         end
         case (state_ff)
            wra_pkg::ST_IDLE: begin
               if (take) begin
                  chan_sel_o <= chan_decode(
                     hold_word_ff[wra_pkg::CHAN_LSB +: wra_pkg::CHAN_W]);
                  auto_ff <= hold_word_ff[wra_pkg::AUTO_BIT];
                  zsup_ff <= hold_word_ff[wra_pkg::ZSUP_BIT];
                  if (hold_word_ff[wra_pkg::AUTO_BIT]) begin
                     gain_o <= wra_pkg::GAIN_MIN;
                  end else if (hold_word_ff[wra_pkg::GAIN_LSB +:
                     wra_pkg::GAIN_W] > wra_pkg::GAIN_MAX) begin
                     gain_o <= wra_pkg::GAIN_MAX;
                  end else begin
                     gain_o <= hold_word_ff[wra_pkg::GAIN_LSB +:
                        wra_pkg::GAIN_W];
                  end
                  wait_ff <= 16'(wra_pkg::SETTLE_CYC);
                  state_ff <= wra_pkg::ST_SETTLE;
               end
            end
            wra_pkg::ST_SETTLE: begin
               if (wait_ff == 16'h0000) begin
                  if (auto_ff) begin
                     state_ff <= wra_pkg::ST_RANGE;
                  end else begin
                     wait_ff <= 16'(wra_pkg::SAMPLE_CYC);
                     state_ff <= wra_pkg::ST_SAMPLE;
                  end
               end
            end
            wra_pkg::ST_RANGE: begin
               // Below 3/8 of full scale a doubling still stays in range.
               if (amp_cmp_i && gain_o != wra_pkg::GAIN_MAX) begin
                  gain_o <= gain_o + 4'h1;
                  wait_ff <= 16'(wra_pkg::SETTLE_CYC);
                  state_ff <= wra_pkg::ST_SETTLE;
               end else begin
                  wait_ff <= 16'(wra_pkg::SAMPLE_CYC);
                  state_ff <= wra_pkg::ST_SAMPLE;
               end
            end
            wra_pkg::ST_SAMPLE: begin
               if (wait_ff == 16'h0000 && period_ff == 16'h0000) begin
                  state_ff <= wra_pkg::ST_START;
               end
            end
            wra_pkg::ST_START: begin
               // The hold stays set while the converter is busy and fire sets it
               // again as busy drops, so a late start gets no tracking gap first.
               if (fire) begin
                  state_ff <= wra_pkg::ST_IDLE;
               end
            end
            default: begin
               state_ff <= wra_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Throughput pacing
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         period_ff <= '0;
      end else if (fire) begin
         if (auto_ff) begin
            period_ff <= 16'(PER_AUTO - 1);
         end else if (zsup_ff) begin
            period_ff <= 16'(PER_ZS - 1);
         end else begin
            period_ff <= 16'(PER_STD - 1);
         end
      end else if (period_ff != 16'h0000) begin
         period_ff <= period_ff - 16'h0001;
      end
   end

   // ==========================================================
   // Converter side outputs
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hold_o <= 1'b0;
         conv_gain_ff <= '0;
         dac_o <= '0;
         ofs_dac_o <= '0;
         busy_o <= 1'b0;
      end else begin
         hold_o <= fire || (cv.busy && !cv.done);
         if (fire) begin
            conv_gain_ff <= gain_o;
         end
         dac_o <= cv.dac;
         ofs_dac_o <= zsup_ff ? ofs_ff : '0;
         busy_o <= pend_ff || (state_ff != wra_pkg::ST_IDLE) || cv.busy;
      end
   end

   // ==========================================================
   // Double buffer and ready flag
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage_ff <= '0;
         stage_vld_ff <= 1'b0;
         result_o <= '0;
         ready_o <= 1'b0;
      end else begin
         if (cv.done) begin
            stage_ff <= {cv.result, conv_gain_ff};
            stage_vld_ff <= 1'b1;
         end else if (load) begin
            stage_vld_ff <= 1'b0;
         end
         if (load) begin
            result_o <= stage_ff;
            ready_o <= 1'b1;
         end else if (read_i) begin
            ready_o <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Serial output, result first, most significant bit first
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shift_ff <= '0;
         shift_cnt_ff <= '0;
         ser_data_o <= 1'b0;
         ser_valid_o <= 1'b0;
      end else if (load) begin
         shift_ff <= {stage_ff[wra_pkg::SER_W-2:0], 1'b0};
         ser_data_o <= stage_ff[wra_pkg::SER_W-1];
         ser_valid_o <= 1'b1;
         shift_cnt_ff <= 5'(wra_pkg::SER_W - 1);
      end else if (shift_cnt_ff != 5'h00) begin
         ser_data_o <= shift_ff[wra_pkg::SER_W-1];
         shift_ff <= {shift_ff[wra_pkg::SER_W-2:0], 1'b0};
         shift_cnt_ff <= shift_cnt_ff - 5'h01;
      end else begin
         ser_valid_o <= 1'b0;
         ser_data_o <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   hold_capture_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cmd_valid_i |=> hold_word_ff == $past(cmd_word_i))
      else $error("command word not captured");
   chan_onehot_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      take |=> $onehot(chan_sel_o) && chan_sel_o[$past(
         hold_word_ff[wra_pkg::CHAN_W-1:0])])
      else $error("channel select not one-hot");
   gain_range_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      gain_o <= wra_pkg::GAIN_MAX)
      else $error("gain code out of range");
   auto_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (take && hold_word_ff[wra_pkg::AUTO_BIT]) |=> gain_o == 4'h0)
      else $error("autorange did not start at lowest gain");
   range_step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state_ff == wra_pkg::ST_RANGE && amp_cmp_i && gain_o != 4'hb)
      |=> gain_o == $past(gain_o) + 4'h1)
      else $error("autorange did not step up");
   pace_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      fire |=> !fire [*8])
      else $error("conversions too close together");
   ready_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (ready_o && !read_i) |=> ready_o)
      else $error("ready dropped without a read");
   offset_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !zsup_ff |=> ofs_dac_o == '0)
      else $error("offset driven without suppression");
   ser_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      load |=> ser_valid_o && ser_data_o == $past(stage_ff[15]))
      else $error("serial shift did not start");

   // ==========================================================
   // Pacing monitor
   // Cycles since the last start are counted apart from the pacing
   // counter, so a fault in that counter cannot hide from the check.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap_ff <= '1;
         need_ff <= '0;
      end else if (fire) begin
         gap_ff <= '0;
         if (auto_ff) begin
            need_ff <= 16'(PER_AUTO - 1);
         end else if (zsup_ff) begin
            need_ff <= 16'(PER_ZS - 1);
         end else begin
            need_ff <= 16'(PER_STD - 1);
         end
      end else if (gap_ff != '1) begin
         gap_ff <= gap_ff + 16'h0001;
      end
   end

   pace_gap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      fire |-> gap_ff >= need_ff)
      else $error("start came before the pacing period ended");
endmodule

// ==== design/wra_pkg.sv ====
// Constants and types shared by the wide range converter sequencer.
// Overview of operation
// - Capture each incoming address-gain word into the holding register on arrival.
// - Decode held word into one-hot channel gate select and amplifier gain.
// - Sequencer steps select, sample, digitize without further host action.
// - Gain is one of twelve, from word or chosen automatically.
// - Automatic ranging ends on highest gain that does not overflow 12 bits.
// - Automatic ranging uses amplifier comparator before conversion starts.
// - Result is 11 bits plus sign, done within 15 us of start.
// - Result shifts out serially in two's complement.
// - Next channel selects and settles while previous sample converts.
// - Results double-buffered so completed value stays readable during next conversion.
// - Throughput 20 KHz standard, 10 KHz zero suppressed, 6 KHz autoranged.
// - Zero suppression holds 14-bit plus sign offset for offset converter.
// - Gain code picks twelve binary ranges from 5 mV to 10.24 V.
// - Channel address covers 512 channels in groups of eight.
package wra_pkg;
   // ==========================================================
   // Command word layout
   localparam int CHAN_W = 9;
   localparam int NCHAN = 512;
   localparam int GROUP_SIZE = 8;
   localparam int GAIN_W = 4;
   localparam int CMD_W = 15;
   localparam int CHAN_LSB = 0;
   localparam int GAIN_LSB = 9;
   localparam int AUTO_BIT = 13;
   localparam int ZSUP_BIT = 14;
   localparam logic [3:0] GAIN_MAX = 4'hb;
   localparam logic [3:0] GAIN_MIN = 4'h0;
   localparam int RES_W = 12;
   localparam int OFS_W = 15;
   localparam int SER_W = 16;
   // ==========================================================
   // Timing, 100 MHz clock
   localparam int CLK_NS = 10;
   localparam int CONV_MAX_NS = 15000;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
   localparam int SAR_STEP_CYC = CONV_MAX_CYC / (RES_W + 1);
   localparam int SETTLE_NS = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SAMPLE_NS = 1000;
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PER_STD_NS = 50000;
   localparam int PER_ZS_NS = 100000;
   localparam int PER_AUTO_NS = 166666;
   localparam int PER_STD_CYC = PER_STD_NS / CLK_NS;
   localparam int PER_ZS_CYC = PER_ZS_NS / CLK_NS;
   localparam int PER_AUTO_CYC = PER_AUTO_NS / CLK_NS;
   localparam logic [RES_W-1:0] SAR_MSB = 12'h800;
   // ==========================================================
   // Sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_SETTLE = 5'b00010,
      ST_RANGE = 5'b00100,
      ST_SAMPLE = 5'b01000,
      ST_START = 5'b10000
   } wra_state_type;
endpackage

// ==== design/wra_conv_if.sv ====
// Handshake between the sequencer and the converter.
`timescale 1ns/1ps
interface wra_conv_if;
   logic start;
   logic busy;
   logic done;
   logic cmp;
   logic [wra_pkg::RES_W-1:0] dac;
   logic [wra_pkg::RES_W-1:0] result;
   modport seq (output start, output cmp, input busy, input done,
      input dac, input result);
   modport conv (input start, input cmp, output busy, output done,
      output dac, output result);
endinterface

// ==== design/wra_sar.sv ====
// Successive approximation converter control.
`timescale 1ns/1ps
module wra_sar (
   input wire logic clk_i,
   input wire logic nrst_i,
   wra_conv_if.conv cv
);
   logic [wra_pkg::RES_W-1:0] code_ff;
   logic [wra_pkg::RES_W-1:0] bit_ff;
   logic [15:0] step_ff;
   logic busy_ff;
   logic done_ff;
   logic [wra_pkg::RES_W-1:0] res_ff;
   logic [15:0] age_ff;

   // ==========================================================
   // Bit trials
   // The code is offset binary; flipping the top bit gives two's complement.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         code_ff <= '0;
         bit_ff <= '0;
         step_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         res_ff <= '0;
      end else begin
         done_ff <= 1'b0;
         if (cv.start && !busy_ff) begin
            busy_ff <= 1'b1;
            code_ff <= wra_pkg::SAR_MSB;
            bit_ff <= wra_pkg::SAR_MSB;
            step_ff <= 16'(wra_pkg::SAR_STEP_CYC - 1);
         end else if (busy_ff) begin
            if (step_ff != 16'h0000) begin
               step_ff <= step_ff - 16'h0001;
            end else if (bit_ff == '0) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
               res_ff <= {~code_ff[wra_pkg::RES_W-1],
                  code_ff[wra_pkg::RES_W-2:0]};
            end else begin
               step_ff <= 16'(wra_pkg::SAR_STEP_CYC - 1);
               bit_ff <= bit_ff >> 1;
               code_ff <= (cv.cmp ? code_ff : (code_ff & ~bit_ff))
                  | (bit_ff >> 1);
            end
         end
      end
   end

   assign cv.busy = busy_ff;
   assign cv.done = done_ff;
   assign cv.dac = code_ff;
   assign cv.result = res_ff;

   // ==========================================================
   // Conversion time monitor
   // The bound is longer than a delay range may reach, so the age of the
   // running conversion is counted here and checked against the limit.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         age_ff <= '0;
      end else if (cv.start && !busy_ff) begin
         age_ff <= '0;
      end else if (busy_ff) begin
         age_ff <= age_ff + 16'h0001;
      end
   end

   conv_bound_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      busy_ff |-> age_ff < 16'(wra_pkg::CONV_MAX_CYC))
      else $error("conversion exceeded its time limit");
endmodule

// ==== dv/wra_afe_model.sv ====
// Analog front end model: amplifier and converter comparators.
`timescale 1ns/1ps
module wra_afe_model (
   input wire logic [wra_pkg::RES_W-1:0] dac_i,
   input wire logic [wra_pkg::GAIN_W-1:0] gain_i,
   input wire logic [wra_pkg::RES_W-1:0] vin_i,
   input wire logic [wra_pkg::GAIN_W-1:0] top_gain_i,
   output logic sar_cmp_o,
   output logic amp_cmp_o
);
   // ==========================================================
   // Comparators
   // Headroom is reported while the gain is below what the signal tolerates.
   assign amp_cmp_o = gain_i < top_gain_i;
   // The held input sits half a step above vin, so equal trials are kept.
   assign sar_cmp_o = vin_i >= dac_i;
endmodule

// ==== dv/wra_top_tb.sv ====
// Self-checking testbench for the converter sequencer.
`timescale 1ns/1ps
module wra_top_tb;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic [14:0] cmd_word_i = 15'h0000;
   logic ofs_valid_i = 1'b0;
   logic [14:0] ofs_word_i = 15'h0000;
   logic read_i = 1'b0;
   logic [11:0] vin = 12'h3a5;
   logic [3:0] top_gain = 4'h0;
   logic amp_cmp_i, sar_cmp_i, hold_o, ready_o, ser_data_o, ser_valid_o;
   logic busy_o;
   logic [511:0] chan_sel_o;
   logic [3:0] gain_o;
   logic [11:0] dac_o;
   logic [14:0] ofs_dac_o;
   logic [15:0] result_o;
   int fail_count = 0;
   int check_count = 0;
   always #5 clk_i = ~clk_i;
   wra_top #(.PER_STD(40), .PER_ZS(60), .PER_AUTO(80)) i_wra_top (
      .clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
      .cmd_word_i(cmd_word_i), .ofs_valid_i(ofs_valid_i),
      .ofs_word_i(ofs_word_i), .amp_cmp_i(amp_cmp_i),
      .sar_cmp_i(sar_cmp_i), .read_i(read_i), .chan_sel_o(chan_sel_o),
      .gain_o(gain_o), .hold_o(hold_o), .dac_o(dac_o),
      .ofs_dac_o(ofs_dac_o), .result_o(result_o), .ready_o(ready_o),
      .ser_data_o(ser_data_o), .ser_valid_o(ser_valid_o), .busy_o(busy_o));
   wra_afe_model i_wra_afe_model (.dac_i(dac_o), .gain_i(gain_o),
      .vin_i(vin), .top_gain_i(top_gain), .sar_cmp_o(sar_cmp_i),
      .amp_cmp_o(amp_cmp_i));
   // ==========================================================
   // Shared tasks
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask
   task automatic check(input string what, input logic [511:0] seen,
         input logic [511:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic send(input logic [14:0] w);
      cmd_word_i = w;
      cmd_valid_i = 1'b1;
      tick;
      cmd_valid_i = 1'b0;
   endtask
   // Bounded wait for a signal level; a hang ends the run.
   task automatic wait_for(input int which, output int held);
      int n;
      held = 0;
      n = 0;
      while (!((which == 0) ? ready_o === 1'b1 :
            (which == 1) ? hold_o === 1'b1 : busy_o === 1'b0)) begin
         if (hold_o === 1'b1) held++;
         tick;
         n++;
         if (n > 6000) begin
            fail_count++;
            $display("CHECK FAILED wait %0d expected done seen hang", which);
            summarize;
         end
      end
   endtask
   // A read that meets a staged result loads it at once, so ready stays.
   task automatic read_out(input logic exp_ready);
      read_i = 1'b1;
      tick;
      read_i = 1'b0;
      tick;
      check("ready after read", ready_o, exp_ready);
   endtask
   // ==========================================================
   // Scenarios
   task automatic sc_programmed;
      int held;
      logic [15:0] bits;
      send(15'h1fff);
      tick;
      tick;
      check("one-hot select", chan_sel_o, 512'h1 << 511);
      check("clamped gain", gain_o, 4'hb);
      check("no offset", ofs_dac_o, 15'h0000);
      wait_for(0, held);
      check("convert time", held <= 1500, 1'b1);
      check("final trial", dac_o, vin);
      check("result word", result_o, {vin ^ 12'h800, 4'hb});
      check("ready held", ready_o, 1'b1);
      for (int i = 0; i < 16; i++) begin
         check("serial valid", ser_valid_o, 1'b1);
         bits = {bits[14:0], ser_data_o};
         tick;
      end
      check("serial frame", bits, {vin ^ 12'h800, 4'hb});
      read_out(1'b0);
   endtask
   task automatic sc_auto;
      logic [3:0] tops [3] = '{4'h0, 4'h5, 4'hf};
      logic [3:0] exp;
      int held;
      foreach (tops[i]) begin
         top_gain = tops[i];
         exp = (tops[i] > 4'hb) ? 4'hb : tops[i];
         send(15'h3e21);
         tick;
         tick;
         check("auto start gain", gain_o, 4'h0);
         wait_for(0, held);
         check("auto gain", gain_o, exp);
         check("auto result", result_o, {vin ^ 12'h800, exp});
         read_out(1'b0);
      end
      top_gain = 4'h0;
   endtask
   task automatic sc_overlap;
      int held;
      send(15'h0403);
      wait_for(1, held);
      send(15'h0e0a);
      tick;
      tick;
      // Selection moves on while the previous sample is still held.
      check("next select", chan_sel_o, 512'h1 << 10);
      check("still holding", hold_o, 1'b1);
      wait_for(0, held);
      check("first result", result_o, {vin ^ 12'h800, 4'h2});
      wait_for(2, held);
      check("first kept", result_o, {vin ^ 12'h800, 4'h2});
      check("first unread", ready_o, 1'b1);
      read_out(1'b1);
      wait_for(0, held);
      check("second result", result_o, {vin ^ 12'h800, 4'h7});
      read_out(1'b0);
   endtask
   task automatic sc_zero_suppress;
      int held;
      ofs_word_i = 15'h4abc;
      ofs_valid_i = 1'b1;
      tick;
      ofs_valid_i = 1'b0;
      send(15'h4405);
      tick;
      tick;
      check("offset word", ofs_dac_o, 15'h4abc);
      wait_for(0, held);
      check("zs result", result_o, {vin ^ 12'h800, 4'h2});
      read_out(1'b0);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      check("reset select", chan_sel_o, 512'h0);
      check("reset ready", ready_o, 1'b0);
      check("reset busy", busy_o, 1'b0);
      sc_programmed;
      sc_auto;
      sc_overlap;
      vin = 12'hc40;
      sc_zero_suppress;
      summarize;
   end
endmodule
